// ---- core/nsl_top.sv ----
// Node number and status LED block with AHB-Lite register slave
module nsl_top #(
  parameter int CLK_HZ = nsl_pkg::NSL_CLK_HZ
) (
  input wire logic hclk, // System clock
  input wire logic hresetn, // Async reset, low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write strobe
  input wire logic [2:0] hsize, // Transfer size
  input wire logic hready, // Bus ready in
  input wire logic [31:0] hwdata, // Write data
  output logic [31:0] hrdata, // Read data
  output logic hreadyout, // Slave ready
  output logic hresp, // Always OKAY
  input wire logic [3:0] node_number_switch, // Coding switch pins
  input wire logic loader_enable_plug, // Plug contact, high when closed
  output logic [7:0] node_number, // Active node number
  output logic default_params, // Running on default parameters
  output logic loader_enable, // Bootstrap loader unlocked
  output logic led_green, // LED green drive
  output logic led_red, // LED red drive
  output logic irq // Level interrupt
);
  import nsl_pkg::*;

  // Pin synchronisers
  logic [3:0] sw_s1_ff;
  logic [3:0] sw_s2_ff;
  logic plug_s1_ff;
  logic plug_s2_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_s1_ff <= 4'h0;
      sw_s2_ff <= 4'h0;
      plug_s1_ff <= 1'b0;
      plug_s2_ff <= 1'b0;
    end else begin
      sw_s1_ff <= node_number_switch;
      sw_s2_ff <= sw_s1_ff;
      plug_s1_ff <= loader_enable_plug;
      plug_s2_ff <= plug_s1_ff;
    end
  end

  // Reset-time capture: switch is sampled once the synchroniser has filled
  logic [1:0] boot_cnt_ff;
  logic in_reset_ff;
  logic default_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      boot_cnt_ff <= 2'h0;
      in_reset_ff <= 1'b1;
      default_ff <= 1'b0;
    end else if (in_reset_ff) begin
      boot_cnt_ff <= 2'(boot_cnt_ff + 2'h1);
      if (boot_cnt_ff == 2'h2) begin
        in_reset_ff <= 1'b0;
        default_ff <= (sw_s2_ff == 4'h0);
      end
    end
  end

  // AHB-Lite address phase capture
  logic wr_pend_ff;
  logic rd_pend_ff;
  logic [7:0] addr_ff;
  logic take;
  assign take = hsel && hready && htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      addr_ff <= 8'h00;
    end else begin
      wr_pend_ff <= take && hwrite;
      rd_pend_ff <= take && !hwrite;
      if (take) begin
        addr_ff <= haddr[7:0];
      end
    end
  end

  function automatic logic hit(input logic pend, input logic [7:0] a, input logic [7:0] ofs);
    hit = pend && (a == ofs);
  endfunction : hit

  // Control register: firmware state flags
  logic [4:0] ctrl_ff;
  logic cfg_live_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= NSL_RST_CTRL[4:0];
    end else if (hit(wr_pend_ff, addr_ff, NSL_OFS_CTRL)) begin
      ctrl_ff <= hwdata[4:0];
    end
  end

  // Live configuration flag stays 0; the end of reset clears it and never loads the pending bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_live_ff <= 1'b0;
    end else if (in_reset_ff && boot_cnt_ff == 2'h2) begin
      cfg_live_ff <= 1'b0;
    end
  end

  // Programmed node number; bit 8 says it overrides the switch
  logic [7:0] prog_node_ff;
  logic prog_valid_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prog_node_ff <= 8'h00;
      prog_valid_ff <= 1'b0;
    end else if (hit(wr_pend_ff, addr_ff, NSL_OFS_NODE)) begin
      prog_node_ff <= hwdata[7:0];
      prog_valid_ff <= hwdata[NSL_NODE_PROG];
    end
  end

  logic [7:0] sw_node;
  assign sw_node = {4'h0, sw_s2_ff};
  logic [7:0] node_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      node_ff <= 8'h00;
    end else if (prog_valid_ff) begin
      node_ff <= prog_node_ff;
    end else begin
      node_ff <= sw_node;
    end
  end
  assign node_number = node_ff;

  // Loader lock follows the plug contact
  logic loader_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      loader_ff <= 1'b0;
    end else begin
      loader_ff <= plug_s2_ff && !in_reset_ff;
    end
  end
  assign loader_enable = loader_ff;
  assign default_params = default_ff;

  // Interrupt events: switch change and plug change
  logic [3:0] sw_prev_ff;
  logic plug_prev_ff;
  logic [NSL_IRQ_BITS-1:0] ev;
  logic [NSL_IRQ_BITS-1:0] irq_stat_ff;
  logic [NSL_IRQ_BITS-1:0] irq_mask_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_prev_ff <= 4'h0;
      plug_prev_ff <= 1'b0;
    end else begin
      sw_prev_ff <= sw_s2_ff;
      plug_prev_ff <= plug_s2_ff;
    end
  end
  always_comb begin
    ev = '0;
    ev[NSL_IRQ_SWITCH] = !in_reset_ff && (sw_prev_ff != sw_s2_ff);
    ev[NSL_IRQ_LOADER] = !in_reset_ff && (plug_prev_ff != plug_s2_ff);
  end

  // Write-one-to-clear bits as they stand in the data phase
  logic [NSL_IRQ_BITS-1:0] clr_bits;
  assign clr_bits = hwdata[NSL_IRQ_BITS-1:0];

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_ff <= '0;
    end else if (hit(wr_pend_ff, addr_ff, NSL_OFS_IRQ_STAT)) begin
      irq_stat_ff <= (irq_stat_ff & ~clr_bits) | ev;
    end else begin
      irq_stat_ff <= irq_stat_ff | ev;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask_ff <= NSL_RST_MASK[NSL_IRQ_BITS-1:0];
    end else if (hit(wr_pend_ff, addr_ff, NSL_OFS_IRQ_MASK)) begin
      irq_mask_ff <= hwdata[NSL_IRQ_BITS-1:0];
    end
  end
  assign irq = |(irq_stat_ff & irq_mask_ff);

  // Register word seen by a read of byte offset a
  function automatic logic [31:0] rd_word(input logic [7:0] a);
    rd_word = 32'h0000_0000;
    case (a)
      NSL_OFS_CTRL: rd_word = {27'h0, ctrl_ff};
      NSL_OFS_NODE: rd_word = {23'h0, prog_valid_ff, prog_node_ff};
      NSL_OFS_STAT: rd_word = {16'h0, 1'b0, cfg_live_ff, sw_s2_ff, loader_ff, default_ff, node_ff};
      NSL_OFS_IRQ_STAT: rd_word = {30'h0, irq_stat_ff};
      NSL_OFS_IRQ_MASK: rd_word = {30'h0, irq_mask_ff};
      default: rd_word = 32'h0000_0000;
    endcase
  endfunction : rd_word

  // A read taken while a write is still in its data phase would return the old word;
  // one wait state lets the write land, then the word is fetched again
  logic rd_late_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_late_ff <= 1'b0;
    end else begin
      rd_late_ff <= take && !hwrite && wr_pend_ff;
    end
  end

  // Read data driven from a register during the data phase
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  always_comb begin
    nxt_rdata = rd_late_ff ? rd_word(addr_ff) : rd_word(haddr[7:0]);
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_ff <= 32'h0000_0000;
    end else if ((take && !hwrite) || rd_late_ff) begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign hrdata = rdata_ff;
  assign hreadyout = !rd_late_ff;
  assign hresp = 1'b0;

  // Pattern selection; error outranks default, bootstrap outranks both
  nsl_led_if led_bus();
  always_comb begin
    if (plug_s2_ff && ctrl_ff[NSL_CTRL_BOOT]) begin
      led_bus.pat = NSL_PAT_BOOT;
    end else if (ctrl_ff[NSL_CTRL_EEERR]) begin
      led_bus.pat = NSL_PAT_EEERR;
    end else if (default_ff) begin
      led_bus.pat = NSL_PAT_DEFAULT;
    end else if (ctrl_ff[NSL_CTRL_MASTER] && !ctrl_ff[NSL_CTRL_NETUP]) begin
      led_bus.pat = NSL_PAT_MASTER;
    end else begin
      led_bus.pat = NSL_PAT_STEADY;
    end
  end
  assign led_bus.in_reset = in_reset_ff;

  nsl_blinker #(.CLK_HZ(CLK_HZ)) u_blink (
    .hclk(hclk),
    .hresetn(hresetn),
    .led(led_bus)
  );
  assign led_green = (led_bus.colour == NSL_GREEN);
  assign led_red = (led_bus.colour == NSL_RED);

  a_led_dark_reset: assert property (@(posedge hclk) disable iff (!hresetn)
    in_reset_ff |=> !led_green && !led_red) else $error("LED lit during reset");
  a_node_upper_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    !prog_valid_ff |=> node_number[7:4] == 4'h0) else $error("Upper node bits not zero");
  a_node_prog_use: assert property (@(posedge hclk) disable iff (!hresetn)
    prog_valid_ff && $stable(prog_node_ff) |=> node_number == $past(prog_node_ff)) else $error("Prog node unused");
  a_node_switch: assert property (@(posedge hclk) disable iff (!hresetn)
    !prog_valid_ff |=> node_number == {4'h0, $past(sw_s2_ff)}) else $error("Switch node unused");
  a_loader_plug: assert property (@(posedge hclk) disable iff (!hresetn)
    !plug_s2_ff |=> !loader_enable) else $error("Loader open without plug");
  a_default_stable: assert property (@(posedge hclk) disable iff (!hresetn)
    !in_reset_ff |=> $stable(default_params)) else $error("Default mode changed");
  a_steady_green: assert property (@(posedge hclk) disable iff (!hresetn)
    led_bus.pat == NSL_PAT_STEADY && !in_reset_ff ##1 led_bus.pat == NSL_PAT_STEADY |-> led_green)
    else $error("Not steady green");
  a_err_priority: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl_ff[NSL_CTRL_EEERR] && !(plug_s2_ff && ctrl_ff[NSL_CTRL_BOOT]) |-> led_bus.pat == NSL_PAT_EEERR)
    else $error("Error pattern not chosen");
  a_cfg_latched: assert property (@(posedge hclk) disable iff (!hresetn)
    !in_reset_ff |=> $stable(cfg_live_ff)) else $error("Config applied without reset");
  a_irq_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    (|ev) |=> (irq_stat_ff & $past(ev)) == $past(ev))
    else $error("Event lost");
  a_irq_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    hit(wr_pend_ff, addr_ff, NSL_OFS_IRQ_STAT) && ev == '0 |=> (irq_stat_ff & $past(clr_bits)) == '0)
    else $error("Status bit not cleared");
  a_read_answer: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_pend_ff |-> ##[0:1] hreadyout)
    else $error("Read data phase not ended");
  a_prog_immediate: assert property (@(posedge hclk) disable iff (!hresetn)
    hit(wr_pend_ff, addr_ff, NSL_OFS_NODE) && hwdata[NSL_NODE_PROG] |=> ##1 node_number == $past(prog_node_ff))
    else $error("Programmed node not applied");
  a_default_capture: assert property (@(posedge hclk) disable iff (!hresetn)
    in_reset_ff && boot_cnt_ff == 2'h2 |=> default_params == ($past(sw_s2_ff) == 4'h0))
    else $error("Default mode not captured");
  a_loader_follow: assert property (@(posedge hclk) disable iff (!hresetn)
    plug_s2_ff && !in_reset_ff |=> loader_enable)
    else $error("Loader locked with plug closed");
  a_boot_plug: assert property (@(posedge hclk) disable iff (!hresetn)
    led_bus.pat == NSL_PAT_BOOT |-> plug_s2_ff)
    else $error("Bootstrap shown without plug");
endmodule : nsl_top

// ---- core/nsl_pkg.sv ----
// Package of constants and types for the node number and status LED block
package nsl_pkg;
  localparam int NSL_CLK_HZ = 25000000;
  localparam logic [7:0] NSL_OFS_CTRL = 8'h00;
  localparam logic [7:0] NSL_OFS_NODE = 8'h04;
  localparam logic [7:0] NSL_OFS_STAT = 8'h08;
  localparam logic [7:0] NSL_OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] NSL_OFS_IRQ_MASK = 8'h10;
  localparam int NSL_CTRL_BOOT = 0;
  localparam int NSL_CTRL_EEERR = 1;
  localparam int NSL_CTRL_MASTER = 2;
  localparam int NSL_CTRL_NETUP = 3;
  localparam int NSL_CTRL_CFG_PEND = 4;
  localparam int NSL_NODE_PROG = 8;
  localparam int NSL_IRQ_SWITCH = 0;
  localparam int NSL_IRQ_LOADER = 1;
  localparam int NSL_IRQ_BITS = 2;
  localparam logic [31:0] NSL_RST_CTRL = 32'h0000_0000;
  localparam logic [31:0] NSL_RST_MASK = 32'h0000_0000;
  localparam int NSL_T100_MS = 100;
  localparam int NSL_T200_MS = 200;
  localparam int NSL_T330_MS = 330;
  localparam int NSL_T500_MS = 500;
  typedef enum {NSL_OFF, NSL_GREEN, NSL_RED} nsl_led_t;
  typedef enum {NSL_PAT_STEADY, NSL_PAT_EEERR, NSL_PAT_BOOT, NSL_PAT_DEFAULT, NSL_PAT_MASTER} nsl_pat_t;
endpackage : nsl_pkg

// ---- core/nsl_led_if.sv ----
// Interface carrying the pattern request from the top to the blinker
interface nsl_led_if;
  import nsl_pkg::*;
  nsl_pat_t pat;
  logic in_reset;
  nsl_led_t colour;
  modport ctl (output pat, output in_reset, input colour);
  modport blk (input pat, input in_reset, output colour);
endinterface : nsl_led_if

// ---- core/nsl_blinker.sv ----
// Blink pattern generator for the two-colour status LED
module nsl_blinker #(
  parameter int CLK_HZ = nsl_pkg::NSL_CLK_HZ
) (
  input wire logic hclk, // System clock
  input wire logic hresetn, // Async reset, low
  nsl_led_if.blk led // Pattern in, colour out
);
  import nsl_pkg::*;
  localparam int CYC_MS = CLK_HZ / 1000;
  localparam logic [31:0] C100 = 32'(NSL_T100_MS * CYC_MS);
  localparam logic [31:0] C200 = 32'(NSL_T200_MS * CYC_MS);
  localparam logic [31:0] C330 = 32'(NSL_T330_MS * CYC_MS);
  localparam logic [31:0] C500 = 32'(NSL_T500_MS * CYC_MS);

  logic [31:0] cnt_ff;
  logic [1:0] phase_ff;
  nsl_pat_t pat_ff;
  nsl_led_t colour_ff;
  logic [31:0] len;
  logic [1:0] nphase;

  // Length of current phase and number of phases per pattern
  always_comb begin
    len = C100;
    nphase = 2'h2;
    case (led.pat)
      NSL_PAT_EEERR: len = C100;
      NSL_PAT_BOOT: len = C200;
      NSL_PAT_DEFAULT: len = (phase_ff == 2'h0) ? C500 : C100;
      NSL_PAT_MASTER: begin
        len = C330;
        nphase = 2'h3;
      end
      default: len = C100;
    endcase
  end

  // Pattern change restarts the sequence at its green phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= 32'h0000_0000;
      phase_ff <= 2'h0;
      pat_ff <= NSL_PAT_STEADY;
    end else begin
      pat_ff <= led.pat;
      if (led.pat != pat_ff || led.in_reset) begin
        cnt_ff <= 32'h0000_0000;
        phase_ff <= 2'h0;
      end else if (cnt_ff + 32'h0000_0001 >= len) begin
        cnt_ff <= 32'h0000_0000;
        phase_ff <= (phase_ff + 2'h1 >= nphase) ? 2'h0 : 2'(phase_ff + 2'h1);
      end else begin
        cnt_ff <= cnt_ff + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      colour_ff <= NSL_OFF;
    end else if (led.in_reset) begin
      colour_ff <= NSL_OFF;
    end else if (led.pat == NSL_PAT_STEADY) begin
      colour_ff <= NSL_GREEN;
    end else begin
      case (phase_ff)
        2'h0: colour_ff <= NSL_GREEN;
        2'h1: colour_ff <= NSL_RED;
        default: colour_ff <= NSL_OFF;
      endcase
    end
  end
  assign led.colour = colour_ff;
endmodule : nsl_blinker

// ---- testbench/nsl_panel_model.sv ----
// Front-panel model: coding switch, loader plug contact and the two-colour LED
module nsl_panel_model (
  input wire logic [3:0] sw_pos, // Position the bench turns to
  input wire logic plug_in, // Coding pin inserted
  input wire logic led_green, // LED green drive
  input wire logic led_red, // LED red drive
  output logic [3:0] node_number_switch, // Switch contacts
  output logic loader_enable_plug, // Plug contact, high when closed
  output logic [1:0] led_colour // Green and red as seen on the LED
);
  timeunit 1ns;
  timeprecision 1ps;
  // Contacts settle well away from the clock edge, as a hand-turned switch would
  assign #7 node_number_switch = sw_pos;
  assign #7 loader_enable_plug = plug_in;
  assign led_colour = {led_green, led_red};
endmodule : nsl_panel_model

// ---- testbench/nsl_top_bench.sv ----
// Self-checking bench for the node number and status LED block
module nsl_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import nsl_pkg::*;
  localparam int HZ = 10000;
  localparam int CPM = HZ / 1000;
  localparam logic [1:0] GRN = 2'b10;
  typedef struct {logic w; logic [31:0] a; logic [31:0] d; logic [31:0] m; logic [31:0] e;} nsl_row_t;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0;
  wire logic hready;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [3:0] sw_pos = 4'h0;
  logic plug_in = 1'b0;
  logic [3:0] node_number_switch;
  logic loader_enable_plug;
  logic [7:0] node_number;
  logic default_params;
  logic loader_enable;
  logic led_green;
  logic led_red;
  logic irq;
  logic [1:0] led_colour;
  logic [31:0] rd;
  int fails = 0;
  int n_compared = 0;
  nsl_row_t rows [8] = '{
    '{1'b0, 32'(NSL_OFS_CTRL), 32'h0, 32'hFFFF_FFFF, 32'h0},
    '{1'b0, 32'(NSL_OFS_IRQ_MASK), 32'h0, 32'hFFFF_FFFF, 32'h0},
    '{1'b0, 32'(NSL_OFS_STAT), 32'h0, 32'h0000_7FFF, 32'h0000_0100},
    '{1'b1, 32'h0000_0020, 32'hFFFF_FFFF, 32'h0, 32'h0},
    '{1'b0, 32'h0000_0020, 32'h0, 32'hFFFF_FFFF, 32'h0},
    '{1'b1, 32'(NSL_OFS_CTRL), 32'h0000_0010, 32'h0, 32'h0},
    '{1'b0, 32'(NSL_OFS_STAT), 32'h0, 32'h0000_4000, 32'h0},
    '{1'b0, 32'(NSL_OFS_CTRL), 32'h0, 32'h0000_001F, 32'h0000_0010}};

  always #20 hclk = ~hclk;
  // One slave on the bus, so its ready is the bus ready
  assign hready = hreadyout;

  nsl_top #(.CLK_HZ(HZ)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .node_number_switch(node_number_switch), .loader_enable_plug(loader_enable_plug),
    .node_number(node_number), .default_params(default_params), .loader_enable(loader_enable),
    .led_green(led_green), .led_red(led_red), .irq(irq));

  nsl_panel_model panel_u (.sw_pos(sw_pos), .plug_in(plug_in), .led_green(led_green), .led_red(led_red),
    .node_number_switch(node_number_switch), .loader_enable_plug(loader_enable_plug), .led_colour(led_colour));

  task final_report;
    if (fails == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task timeout;
    check("wait_bound", 32'h0, 32'h1);
    final_report();
  endtask : timeout

  task cycles(input int n);
    repeat (n) @(posedge hclk);
  endtask : cycles

  task wait_ready;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'b1 && k < 100);
    if (k >= 100) timeout();
  endtask : wait_ready

  task bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'b010;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    r = hrdata;
  endtask : bus

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, 32'(a), d, rd);
  endtask : wr

  task wait_col(input logic [1:0] c, input bit eq);
    int k;
    k = 0;
    while (((led_colour === c) != eq) && k < 30000) begin
      @(negedge hclk);
      k++;
    end
    if (k >= 30000) timeout();
  endtask : wait_col

  task run_len(input logic [1:0] c, output int n);
    n = 0;
    while (led_colour === c && n < 30000) begin
      @(negedge hclk);
      n++;
    end
    if (n >= 30000) timeout();
  endtask : run_len

  // Counts the cycles out of len in which the LED shows green
  task count_green(input int len, output int n);
    n = 0;
    repeat (len) begin
      @(negedge hclk);
      if (led_colour === GRN) n++;
    end
  endtask : count_green

  // Skips the partial first phase, then times one whole green, red and off run
  task pattern(input int g, input int r, input int o);
    int n;
    @(negedge hclk);
    wait_col(GRN, 1'b0);
    wait_col(GRN, 1'b1);
    run_len(GRN, n);
    check("green_len", 32'(n), 32'(g * CPM));
    run_len(2'b01, n);
    check("red_len", 32'(n), 32'(r * CPM));
    run_len(2'b00, n);
    check("off_len", 32'(n), 32'(o * CPM));
  endtask : pattern

  initial begin
    int n;
    repeat (20) @(posedge hclk);
    check("led_in_reset", 32'(led_colour), 32'h0);
    hresetn <= 1'b1;
    cycles(6);
    check("default_params", 32'(default_params), 32'h1);
    foreach (rows[i]) begin
      bus(rows[i].w, rows[i].a, rows[i].d, rd);
      check("hresp", 32'(hresp), 32'h0);
      if (rows[i].m !== 32'h0) check("reg_row", rd & rows[i].m, rows[i].e);
    end
    sw_pos <= 4'h5;
    cycles(8);
    check("node_live", 32'(node_number), 32'h0000_0005);
    pattern(NSL_T500_MS, NSL_T100_MS, 0);
    wr(NSL_OFS_CTRL, 32'h0000_0002);
    pattern(NSL_T100_MS, NSL_T100_MS, 0);
    wr(NSL_OFS_CTRL, 32'h0);
    wr(NSL_OFS_NODE, 32'h0000_01A5);
    cycles(2);
    check("node_prog", 32'(node_number), 32'h0000_00A5);
    bus(1'b0, 32'(NSL_OFS_STAT), 32'h0, rd);
    check("stat_node", rd & 32'h0000_00FF, 32'h0000_00A5);
    // Interrupt: a switch move is held pending while masked, then shown, then cleared
    wr(NSL_OFS_IRQ_MASK, 32'h0);
    wr(NSL_OFS_IRQ_STAT, 32'h0000_0003);
    bus(1'b0, 32'(NSL_OFS_IRQ_STAT), 32'h0, rd);
    check("irq_stat_clr", rd, 32'h0);
    sw_pos <= 4'h6;
    cycles(10);
    bus(1'b0, 32'(NSL_OFS_IRQ_STAT), 32'h0, rd);
    check("irq_stat", rd & 32'h0000_0001, 32'h0000_0001);
    check("irq_masked", 32'(irq), 32'h0);
    wr(NSL_OFS_IRQ_MASK, 32'h0000_0001);
    cycles(1);
    check("irq_on", 32'(irq), 32'h1);
    wr(NSL_OFS_IRQ_STAT, 32'h0000_0001);
    cycles(1);
    check("irq_cleared", 32'(irq), 32'h0);
    // Reset in mid-pattern with a non-zero switch
    hresetn <= 1'b0;
    cycles(2);
    check("led_in_reset", 32'(led_colour), 32'h0);
    sw_pos <= 4'h3;
    cycles(3);
    hresetn <= 1'b1;
    cycles(8);
    check("default_params", 32'(default_params), 32'h0);
    check("node_switch", 32'(node_number), 32'h0000_0003);
    count_green(200, n);
    check("steady_green", 32'(n), 32'd200);
    plug_in <= 1'b1;
    cycles(10);
    check("loader_on", 32'(loader_enable), 32'h1);
    wr(NSL_OFS_CTRL, 32'h0000_0001);
    pattern(NSL_T200_MS, NSL_T200_MS, 0);
    plug_in <= 1'b0;
    cycles(10);
    check("loader_off", 32'(loader_enable), 32'h0);
    // Bootstrap flag still set, but without the plug the LED stays green past a whole boot phase
    count_green(NSL_T200_MS * CPM + 500, n);
    check("boot_locked", 32'(n), 32'(NSL_T200_MS * CPM + 500));
    wr(NSL_OFS_CTRL, 32'h0000_0004);
    pattern(NSL_T330_MS, NSL_T330_MS, NSL_T330_MS);
    // Once the network is started the master shows plain green
    wr(NSL_OFS_CTRL, 32'h0000_000C);
    count_green(NSL_T330_MS * CPM + 100, n);
    check("netup_green", 32'(n), 32'(NSL_T330_MS * CPM + 100));
    final_report();
  end
endmodule : nsl_top_bench
